// *** spg_top.sv ***
// Purpose: pattern generator and pattern checker for stream links
// Assumes: stream partners share clk_in; one-cycle read latency
// Notes: sizes fixed in spg_pkg
`timescale 1ns/1ps
module spg_top #(
  parameter logic [7:0] GEN_SEED = spg_pkg::GEN_SEED_DEF,
  parameter logic [7:0] CHK_SEED = spg_pkg::CHK_SEED_DEF
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic cmd_write_in,
  input wire logic cmd_address_in,
  input wire logic [31:0] cmd_writedata_in,
  output logic cmd_waitrequest_out,
  input wire logic [1:0] gctl_address_in,
  input wire logic gctl_read_in,
  input wire logic gctl_write_in,
  input wire logic [31:0] gctl_writedata_in,
  output logic [31:0] gctl_readdata_out,
  output logic src_valid_out,
  input wire logic src_ready_in,
  output logic [spg_pkg::DW-1:0] src_data_out,
  output logic [spg_pkg::CH_W-1:0] src_channel_out,
  output logic [spg_pkg::ERR_W-1:0] src_error_out,
  output logic src_sop_out,
  output logic src_eop_out,
  output logic [spg_pkg::EMP_W-1:0] src_empty_out,
  input wire logic snk_valid_in,
  output logic snk_ready_out,
  input wire logic [spg_pkg::DW-1:0] snk_data_in,
  input wire logic [spg_pkg::CH_W-1:0] snk_channel_in,
  input wire logic [spg_pkg::ERR_W-1:0] snk_error_in,
  input wire logic snk_sop_in,
  input wire logic snk_eop_in,
  input wire logic [spg_pkg::EMP_W-1:0] snk_empty_in,
  input wire logic [1:0] cctl_address_in,
  input wire logic cctl_read_in,
  input wire logic cctl_write_in,
  input wire logic [31:0] cctl_writedata_in,
  output logic [31:0] cctl_readdata_out
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] spg_lfsr_step(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  function automatic logic spg_thr_hit(input logic [7:0] v, input logic [8:0] thr);
    return {1'b0, v} < thr; // RL8 RL16 RL23
  endfunction

  function automatic logic [31:0] spg_status_word();
    return {spg_pkg::PKT_EN, 7'(spg_pkg::SPB), 8'(spg_pkg::NCH), spg_pkg::CORE_ID}; // RL10 RL21
  endfunction

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic [1:0] rst_sync_r;
  logic rst_n;
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // ----------------------------------------
  // generator
  // ----------------------------------------
  spg_pkg::spg_gstate_type g_state_r, g_state_nxt;
  logic g_en_r, g_en_nxt, g_first_r, g_first_nxt, cmd_wait_r, cmd_wait_nxt;
  logic [8:0] g_thr_r, g_thr_nxt;
  logic [7:0] g_lfsr_r, g_lfsr_nxt;
  logic [31:0] g_hi_r, g_hi_nxt, g_cmd_r, g_cmd_nxt, g_rd_r, g_rd_nxt;
  logic [15:0] g_rem_r, g_rem_nxt, g_pos_cur;
  logic [15:0] g_pos_r [spg_pkg::NCH];
  logic [15:0] g_pos_nxt [spg_pkg::NCH];
  spg_pkg::spg_beat_type s_r, s_nxt;
  logic s_valid_r, s_valid_nxt;
  logic cq_push, cq_pop, cq_valid, g_emit, g_last, g_hit, g_cmd_wr;
  logic [31:0] cq_data;
  logic [4:0] cq_cnt, cq_cnt_nxt;
  logic [spg_pkg::CH_W-1:0] g_ch, n_ch;

  spg_fifo #(.W(32), .D(spg_pkg::CQ_DEPTH)) u_cmd_q (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .in_valid_in(cq_push),
    .in_ready_out(),
    .in_data_in(cmd_writedata_in),
    .out_valid_out(cq_valid),
    .out_ready_in(cq_pop),
    .out_data_out(cq_data),
    .count_out(cq_cnt)
  ); // RL3

  always_comb
  begin
    g_en_nxt = g_en_r;
    g_thr_nxt = g_thr_r;
    g_hi_nxt = g_hi_r;
    g_lfsr_nxt = spg_lfsr_step(g_lfsr_r);
    g_state_nxt = g_state_r;
    g_cmd_nxt = g_cmd_r;
    g_rem_nxt = g_rem_r;
    g_first_nxt = g_first_r;
    g_pos_nxt = g_pos_r;
    s_nxt = s_r;
    s_valid_nxt = s_valid_r;
    cq_pop = 1'b0;
    g_emit = 1'b0;
    g_cmd_wr = cmd_write_in && !cmd_wait_r; // RL5
    cq_push = g_cmd_wr && cmd_address_in == spg_pkg::ADDR_CMD_LOW_WORD; // RL4
    if (g_cmd_wr && cmd_address_in == spg_pkg::ADDR_CMD_HIGH_WORD)
      g_hi_nxt = cmd_writedata_in; // RL6
    if (gctl_write_in && gctl_address_in == spg_pkg::ADDR_CONTROL)
    begin
      g_en_nxt = gctl_writedata_in[spg_pkg::CTL_EN_BIT]; // RL7
      g_thr_nxt = gctl_writedata_in[spg_pkg::CTL_THR_LSB +: spg_pkg::THR_W]; // RL7
    end
    case (gctl_address_in)
      spg_pkg::ADDR_STATUS: g_rd_nxt = spg_status_word(); // RL10
      spg_pkg::ADDR_CONTROL: g_rd_nxt = {15'h0000, g_thr_r, 7'h00, g_en_r};
      spg_pkg::ADDR_FILL: g_rd_nxt = {16'h0000, 9'(cq_cnt), 6'h00,
        g_state_r == spg_pkg::GS_RUN || cq_cnt != 5'h00 || s_valid_r};
      default: g_rd_nxt = 32'h0000_0000;
    endcase
    if (!gctl_read_in)
      g_rd_nxt = g_rd_r;
    g_ch = g_cmd_r[spg_pkg::CMD_CH_LSB +: spg_pkg::CH_W];
    n_ch = cq_data[spg_pkg::CMD_CH_LSB +: spg_pkg::CH_W];
    g_pos_cur = g_pos_r[g_ch]; // RL11
    g_last = g_rem_r <= 16'(spg_pkg::SPB);
    g_hit = spg_thr_hit(g_lfsr_r, g_thr_r); // RL8
    if (src_ready_in)
      s_valid_nxt = 1'b0;
    case (g_state_r)
      spg_pkg::GS_IDLE:
      begin
        if (cq_valid && g_en_r) // RL26
        begin
          cq_pop = 1'b1;
          g_cmd_nxt = cq_data;
          g_rem_nxt = cq_data[15:0];
          g_first_nxt = spg_pkg::PKT_EN && cq_data[spg_pkg::CMD_SOP_BIT]; // RL24
          if (spg_pkg::PKT_EN && cq_data[spg_pkg::CMD_SOP_BIT])
            g_pos_nxt[n_ch] = 16'h0000; // RL1
          g_state_nxt = spg_pkg::GS_RUN;
        end
      end
      spg_pkg::GS_RUN:
      begin
        if (g_rem_r == 16'h0000)
          g_state_nxt = spg_pkg::GS_IDLE;
        else if (g_en_r && g_hit && (!s_valid_r || src_ready_in)) // RL26
        begin
          g_emit = 1'b1;
          s_valid_nxt = 1'b1;
          for (int i = 0; i < spg_pkg::SPB; i++)
            s_nxt.data[spg_pkg::DW-1-spg_pkg::SBW*i -: spg_pkg::SBW] =
              8'(g_pos_cur + 16'(i)) ^ g_hi_r[spg_pkg::HI_MASK_LSB +: 8]; // RL1
          s_nxt.ch = g_ch;
          s_nxt.err = g_hi_r[spg_pkg::HI_ERR_LSB +: spg_pkg::ERR_W];
          s_nxt.sop = g_first_r && !g_hi_r[spg_pkg::HI_NOSOP_BIT];
          s_nxt.eop = 1'b0;
          s_nxt.empty = '0;
          g_first_nxt = 1'b0;
          // short non-final segments are padded to a whole beat
          if (g_last && spg_pkg::PKT_EN && g_cmd_r[spg_pkg::CMD_EOP_BIT])
          begin
            s_nxt.eop = !g_hi_r[spg_pkg::HI_NOEOP_BIT];
            s_nxt.empty = spg_pkg::EMP_W'(16'(spg_pkg::SPB) - g_rem_r); // RL13
            g_pos_nxt[g_ch] = g_pos_cur + g_rem_r;
          end
          else
            g_pos_nxt[g_ch] = g_pos_cur + 16'(spg_pkg::SPB); // RL2
          g_rem_nxt = g_last ? 16'h0000 : g_rem_r - 16'(spg_pkg::SPB);
        end
      end
      default: g_state_nxt = spg_pkg::GS_IDLE;
    endcase
    cq_cnt_nxt = cq_cnt + 5'(cq_push) - 5'(cq_pop);
    cmd_wait_nxt = cq_cnt_nxt == 5'(spg_pkg::CQ_DEPTH); // RL5
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      g_state_r <= spg_pkg::GS_IDLE;
      g_en_r <= spg_pkg::RST_EN;
      g_thr_r <= spg_pkg::RST_THR;
      g_hi_r <= spg_pkg::RST_HI;
      g_lfsr_r <= GEN_SEED; // RL9
      g_cmd_r <= 32'h0000_0000;
      g_rem_r <= 16'h0000;
      g_first_r <= 1'b0;
      g_rd_r <= 32'h0000_0000;
      cmd_wait_r <= 1'b0;
      s_r <= '0;
      s_valid_r <= 1'b0;
      for (int c = 0; c < spg_pkg::NCH; c++)
        g_pos_r[c] <= 16'h0000;
    end
    else
    begin
      g_state_r <= g_state_nxt;
      g_en_r <= g_en_nxt;
      g_thr_r <= g_thr_nxt;
      g_hi_r <= g_hi_nxt;
      g_lfsr_r <= g_lfsr_nxt;
      g_cmd_r <= g_cmd_nxt;
      g_rem_r <= g_rem_nxt;
      g_first_r <= g_first_nxt;
      g_rd_r <= g_rd_nxt;
      cmd_wait_r <= cmd_wait_nxt;
      s_r <= s_nxt;
      s_valid_r <= s_valid_nxt;
      g_pos_r <= g_pos_nxt;
    end
  end

  // ----------------------------------------
  // checker
  // ----------------------------------------
  logic c_en_r, c_en_nxt, c_rdy_r, c_rdy_nxt;
  logic [8:0] c_thr_r, c_thr_nxt;
  logic [7:0] c_lfsr_r, c_lfsr_nxt;
  logic [31:0] c_rd_r, c_rd_nxt, eq_data;
  logic [3:0] c_last_r, c_last_nxt, c_kinds;
  logic [15:0] c_exp_r [spg_pkg::NCH];
  logic [15:0] c_exp_nxt [spg_pkg::NCH];
  logic [spg_pkg::NCH-1:0] c_inpkt_r, c_inpkt_nxt;
  logic [15:0] c_exp, c_nsym;
  logic dq_push, dq_valid, c_pop, eq_push, eq_ready, eq_valid, eq_pop;
  logic [2:0] dq_cnt;
  logic [5:0] eq_cnt;
  spg_pkg::spg_beat_type dq_in, dq_out;

  assign dq_in = '{sop: snk_sop_in, eop: snk_eop_in, empty: snk_empty_in,
    ch: snk_channel_in, err: snk_error_in, data: snk_data_in};
  assign dq_push = snk_valid_in && c_rdy_r;

  spg_fifo #(.W($bits(spg_pkg::spg_beat_type)), .D(spg_pkg::DQ_DEPTH)) u_data_q (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .in_valid_in(dq_push),
    .in_ready_out(),
    .in_data_in(dq_in),
    .out_valid_out(dq_valid),
    .out_ready_in(c_en_r),
    .out_data_out(dq_out),
    .count_out(dq_cnt)
  );

  spg_fifo #(.W(32), .D(spg_pkg::EQ_DEPTH)) u_exc_q (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .in_valid_in(eq_push),
    .in_ready_out(eq_ready),
    .in_data_in({16'h0000, 8'(dq_out.ch), 4'h0, c_kinds}),
    .out_valid_out(eq_valid),
    .out_ready_in(eq_pop),
    .out_data_out(eq_data),
    .count_out(eq_cnt)
  ); // RL17

  always_comb
  begin
    c_en_nxt = c_en_r;
    c_thr_nxt = c_thr_r;
    c_lfsr_nxt = spg_lfsr_step(c_lfsr_r);
    c_last_nxt = c_last_r;
    c_exp_nxt = c_exp_r;
    c_inpkt_nxt = c_inpkt_r;
    c_kinds = 4'h0;
    if (cctl_write_in && cctl_address_in == spg_pkg::ADDR_CONTROL)
    begin
      c_en_nxt = cctl_writedata_in[spg_pkg::CTL_EN_BIT]; // RL21
      c_thr_nxt = cctl_writedata_in[spg_pkg::CTL_THR_LSB +: spg_pkg::THR_W];
    end
    // room is judged one beat ahead since ready is registered
    c_rdy_nxt = c_en_r && spg_thr_hit(c_lfsr_r, c_thr_r)
      && (dq_cnt + 3'(dq_push)) < 3'(spg_pkg::DQ_DEPTH); // RL16 RL26
    c_pop = dq_valid && c_en_r; // RL26
    c_exp = (spg_pkg::PKT_EN && dq_out.sop) ? 16'h0000 : c_exp_r[dq_out.ch]; // RL25
    c_nsym = (spg_pkg::PKT_EN && dq_out.eop)
      ? 16'(spg_pkg::SPB) - 16'(dq_out.empty) : 16'(spg_pkg::SPB);
    for (int i = 0; i < spg_pkg::SPB; i++)
      if (16'(i) < c_nsym && dq_out.data[spg_pkg::DW-1-spg_pkg::SBW*i -: spg_pkg::SBW]
          != 8'(c_exp + 16'(i)))
        c_kinds[spg_pkg::EXC_DATA] = 1'b1; // RL15
    c_kinds[spg_pkg::EXC_SOP] = spg_pkg::PKT_EN && !dq_out.sop && !c_inpkt_r[dq_out.ch];
    c_kinds[spg_pkg::EXC_EOP] = spg_pkg::PKT_EN && dq_out.sop && c_inpkt_r[dq_out.ch];
    c_kinds[spg_pkg::EXC_ERR] = |dq_out.err; // RL17
    if (c_pop)
    begin
      c_last_nxt = c_kinds;
      c_exp_nxt[dq_out.ch] = c_exp + c_nsym; // RL15
      if (spg_pkg::PKT_EN)
        c_inpkt_nxt[dq_out.ch] = (dq_out.sop || c_inpkt_r[dq_out.ch]) && !dq_out.eop;
    end
    // a full queue refuses the push, so the event is lost
    eq_push = c_pop && c_kinds != 4'h0 && c_kinds != c_last_r; // RL18 RL19
    eq_pop = cctl_read_in && cctl_address_in == spg_pkg::ADDR_EXC && eq_valid; // RL20
    case (cctl_address_in)
      spg_pkg::ADDR_STATUS: c_rd_nxt = spg_status_word();
      spg_pkg::ADDR_CONTROL: c_rd_nxt = {15'h0000, c_thr_r, 7'h00, c_en_r};
      spg_pkg::ADDR_EXC: c_rd_nxt = {eq_valid, eq_data[30:0]};
      default: c_rd_nxt = 32'h0000_0000;
    endcase
    if (!cctl_read_in)
      c_rd_nxt = c_rd_r;
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      c_en_r <= spg_pkg::RST_EN;
      c_thr_r <= spg_pkg::RST_THR;
      c_lfsr_r <= CHK_SEED; // RL9
      c_rdy_r <= 1'b0;
      c_last_r <= 4'h0;
      c_inpkt_r <= '0;
      c_rd_r <= 32'h0000_0000;
      for (int c = 0; c < spg_pkg::NCH; c++)
        c_exp_r[c] <= 16'h0000;
    end
    else
    begin
      c_en_r <= c_en_nxt;
      c_thr_r <= c_thr_nxt;
      c_lfsr_r <= c_lfsr_nxt;
      c_rdy_r <= c_rdy_nxt;
      c_last_r <= c_last_nxt;
      c_inpkt_r <= c_inpkt_nxt;
      c_rd_r <= c_rd_nxt;
      c_exp_r <= c_exp_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign cmd_waitrequest_out = cmd_wait_r;
  assign gctl_readdata_out = g_rd_r;
  assign src_valid_out = s_valid_r;
  assign src_data_out = s_r.data;
  assign src_channel_out = s_r.ch;
  assign src_error_out = s_r.err;
  assign src_sop_out = s_r.sop;
  assign src_eop_out = s_r.eop;
  assign src_empty_out = s_r.empty;
  assign snk_ready_out = c_rdy_r;
  assign cctl_readdata_out = c_rd_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n);
  sequence s_beat_take;
    snk_valid_in && c_rdy_r;
  endsequence
  sequence s_exc_read;
    eq_pop && !eq_push;
  endsequence

  a_wait_when_full: assert property (cq_cnt == 5'h10 |-> cmd_waitrequest_out) // RL5
    else $error("queue full without waitrequest");
  a_push_low_only: assert property (cmd_write_in && cmd_address_in |-> !cq_push) // RL4
    else $error("high word write pushed a command");
  a_cmd_count: assert property (cq_push && !cq_pop |=> cq_cnt == $past(cq_cnt) + 5'h01) // RL3
    else $error("command not queued");
  a_thr_zero: assert property (g_thr_r == 9'h000 |-> !g_emit) // RL23
    else $error("beat emitted at throttle zero");
  a_thr_full: assert property (g_state_r == spg_pkg::GS_RUN && g_rem_r != 16'h0000
      && g_en_r && g_thr_r == spg_pkg::THR_FULL && !s_valid_r |-> g_emit) // RL23
    else $error("full throttle did not emit");
  a_sym_pattern: assert property (g_emit |=> src_data_out[31:24]
      == (8'($past(g_pos_cur)) ^ $past(g_hi_r[7:0]))) // RL1
    else $error("symbol pattern wrong");
  a_take_enabled: assert property (s_beat_take |-> $past(c_en_r)) // RL26
    else $error("beat taken while disabled");
  a_exc_read: assert property (s_exc_read |=> eq_cnt == $past(eq_cnt) - 6'h01) // RL20
    else $error("read did not remove descriptor");
  a_exc_dedup: assert property (c_pop && c_kinds == c_last_r |-> !eq_push) // RL18
    else $error("repeated exception queued");
endmodule

// *** spg_pkg.sv ***
// Purpose: constants and types shared by the pattern generator/checker
// Assumes: one clock, widths fixed at build
// Notes: holds the overview below
//
// Overview of operation
// [RL1] output symbol equals its packet position xor the data error mask
// [RL2] without packets, positions run on as one endless stream
// [RL3] 32-bit write-only command port feeding a 16-entry command queue
// [RL4] write to command low word (address 0) pushes; other addresses never push
// [RL5] waitrequest held while the command queue is full
// [RL6] command high word sets error injection; writing zero clears it
// [RL7] 32-bit generator control port: enable and throttle
// [RL8] throttle compared with random source gates each output cycle
// [RL9] each core's random source starts from its own seed
// [RL10] generator status shows channel count and packet support
// [RL11] separate symbol position kept per channel
// [RL12] generator channels, symbols per beat and error width within limits
// [RL13] packet signals active only when packets configured; sop, eop and empty ports always exist, held low or ignored when PKT_EN is 0
// [RL14] data width is a whole multiple of symbol width
// [RL15] checker compares each symbol to per-channel expected position
// [RL16] checker throttle and random source govern its ready output
// [RL17] data, missing sop, missing eop, error exceptions queued, 32 entries
// [RL18] a run of the same exception queues one descriptor
// [RL19] exceptions dropped while the exception queue is full
// [RL20] reading a descriptor removes it from the queue
// [RL21] 32-bit checker control: enable, throttle, channel count, packets
// [RL22] checker symbols per beat, channels and error width within limits
// [RL23] throttle 0 halts, 256 full rate, between proportional
// [RL24] command sop flag ignored without packet support
// [RL25] checker restarts expected position at zero on sop
// [RL26] disabled cores move no beats; queued entries kept; a waiting generator beat still goes, checker ready drops a cycle late
package spg_pkg;
  localparam int SBW = 8;
  localparam int SPB = 4;
  localparam int DW = SBW * SPB; // RL14
  localparam int NCH = 4; // RL12 RL22
  localparam int CH_W = 2;
  localparam int ERR_W = 2;
  localparam int EMP_W = 2;
  localparam bit PKT_EN = 1'b1;
  localparam int CQ_DEPTH = 16;
  localparam int EQ_DEPTH = 32;
  localparam int DQ_DEPTH = 4;
  localparam int THR_W = 9;
  localparam logic [8:0] THR_FULL = 9'h100;
  localparam logic [7:0] GEN_SEED_DEF = 8'h5a;
  localparam logic [7:0] CHK_SEED_DEF = 8'ha7;
  // identity value is arbitrary
  localparam logic [15:0] CORE_ID = 16'h0c3e;
  // register offsets
  localparam logic ADDR_CMD_LOW_WORD = 1'h0;
  localparam logic ADDR_CMD_HIGH_WORD = 1'h1;
  localparam logic [1:0] ADDR_STATUS = 2'h0;
  localparam logic [1:0] ADDR_CONTROL = 2'h1;
  localparam logic [1:0] ADDR_FILL = 2'h2;
  localparam logic [1:0] ADDR_EXC = 2'h2;
  // field positions
  localparam int CTL_EN_BIT = 0;
  localparam int CTL_THR_LSB = 8;
  localparam int CMD_CH_LSB = 16;
  localparam int CMD_SOP_BIT = 30;
  localparam int CMD_EOP_BIT = 31;
  localparam int HI_MASK_LSB = 0;
  localparam int HI_ERR_LSB = 8;
  localparam int HI_NOSOP_BIT = 16;
  localparam int HI_NOEOP_BIT = 17;
  localparam int FILL_LSB = 7;
  localparam int EXC_DATA = 0;
  localparam int EXC_SOP = 1;
  localparam int EXC_EOP = 2;
  localparam int EXC_ERR = 3;
  localparam int EXC_CH_LSB = 8;
  localparam int EXC_VALID_BIT = 31;
  // reset values
  localparam logic RST_EN = 1'b0;
  localparam logic [8:0] RST_THR = 9'h000;
  localparam logic [31:0] RST_HI = 32'h0000_0000;

  typedef enum logic [1:0] {
    GS_IDLE = 2'b01,
    GS_RUN = 2'b10
  } spg_gstate_type;

  typedef struct packed {
    logic sop;
    logic eop;
    logic [EMP_W-1:0] empty;
    logic [CH_W-1:0] ch;
    logic [ERR_W-1:0] err;
    logic [DW-1:0] data;
  } spg_beat_type;
endpackage

// *** spg_fifo.sv ***
// Purpose: small queue with valid/ready on both sides
// Assumes: depth is a power of two
// Notes: read data comes from a register
`timescale 1ns/1ps
module spg_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out,
  output logic [$clog2(D+1)-1:0] count_out
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D+1);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [W-1:0] dout_r, dout_nxt;
  logic push, pop;

  always_comb
  begin
    push = in_valid_in && in_ready_out;
    pop = out_valid_out && out_ready_in;
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + CW'(push) - CW'(pop);
    // bypass: a word written into the head slot is seen after the next edge
    dout_nxt = (push && wp_r == rp_nxt) ? in_data_in : mem_r[rp_nxt];
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      dout_r <= '0;
    end
    else
    begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      dout_r <= dout_nxt;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (push)
      mem_r[wp_r] <= in_data_in;
  end

  assign in_ready_out = cnt_r != CW'(D);
  assign out_valid_out = cnt_r != '0;
  assign out_data_out = dout_r;
  assign count_out = cnt_r;
endmodule

// *** spg_loop.sv ***
// Purpose: stream loopback standing in for the link under test
// Assumes: shares the core clock; combinational path
// Notes: stall_in holds both sides off
`timescale 1ns/1ps
// ----------------------------------------
// loopback partner
// ----------------------------------------
module spg_loop (
  input wire logic stall_in,
  input wire logic src_valid_in,
  output logic src_ready_out,
  input wire spg_pkg::spg_beat_type beat_in,
  output logic snk_valid_out,
  input wire logic snk_ready_in,
  output spg_pkg::spg_beat_type beat_out
);
  assign snk_valid_out = src_valid_in & ~stall_in;
  assign src_ready_out = snk_ready_in & ~stall_in;
  // stalled lines show inverted data, never the last beat
  assign beat_out = stall_in ? ~beat_in : beat_in;
endmodule

// *** stream_pattern_gen_checker_bench.sv ***
// Purpose: self-checking bench for spg_top
// Assumes: loopback from generator to checker
// Notes: throttles run at full rate so beat timing stays short
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
  $display("unexpected %0t value mismatch", $time); end end
// ----------------------------------------
// bench top
// ----------------------------------------
module stream_pattern_gen_checker_bench;
  logic clk_in = 0, rst_n_in = 0, stall = 0, cmd_write = 0, cmd_address = 0, cmd_wait;
  logic g_rd = 0, g_wr = 0, c_rd = 0, c_wr = 0, src_valid, src_ready, snk_valid, snk_ready;
  logic [1:0] g_addr = '0, c_addr = '0;
  logic [31:0] cmd_wdata = '0, g_wdata = '0, c_wdata = '0, g_rdata, c_rdata, rd;
  spg_pkg::spg_beat_type gb, sb, b;
  int bad_count = 0, n_tests = 0, cyc = 0;
  spg_top spg_top_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_write_in(cmd_write),
    .cmd_address_in(cmd_address), .cmd_writedata_in(cmd_wdata), .cmd_waitrequest_out(cmd_wait),
    .gctl_address_in(g_addr), .gctl_read_in(g_rd), .gctl_write_in(g_wr),
    .gctl_writedata_in(g_wdata), .gctl_readdata_out(g_rdata), .src_valid_out(src_valid),
    .src_ready_in(src_ready), .src_data_out(gb.data), .src_channel_out(gb.ch),
    .src_error_out(gb.err), .src_sop_out(gb.sop), .src_eop_out(gb.eop),
    .src_empty_out(gb.empty), .snk_valid_in(snk_valid), .snk_ready_out(snk_ready),
    .snk_data_in(sb.data), .snk_channel_in(sb.ch), .snk_error_in(sb.err), .snk_sop_in(sb.sop),
    .snk_eop_in(sb.eop), .snk_empty_in(sb.empty), .cctl_address_in(c_addr),
    .cctl_read_in(c_rd), .cctl_write_in(c_wr), .cctl_writedata_in(c_wdata),
    .cctl_readdata_out(c_rdata));
  spg_loop spg_loop_inst (.stall_in(stall), .src_valid_in(src_valid), .src_ready_out(src_ready),
    .beat_in(gb), .snk_valid_out(snk_valid), .snk_ready_in(snk_ready), .beat_out(sb));
  initial
  begin
    forever #5 clk_in = ~clk_in;
  end
  // a hang costs a mismatch instead of a stuck run
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("tests %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // held until an edge sees waitrequest low
  task automatic cmd_wr(input logic a, input logic [31:0] d);
    logic w;
    @(posedge clk_in);
    #1;
    cmd_write = 1;
    cmd_address = a;
    cmd_wdata = d;
    do
    begin
      @(negedge clk_in);
      w = cmd_wait;
      @(posedge clk_in);
    end while (w !== 1'b0);
    #1 cmd_write = 0;
  endtask
  task automatic ctl(input bit c, input bit wr, input logic [1:0] a, input logic [31:0] d);
    @(posedge clk_in);
    #1;
    {g_addr, c_addr, g_wdata, c_wdata} = {a, a, d, d};
    {g_rd, g_wr, c_rd, c_wr} = {!c && !wr, !c && wr, c && !wr, c && wr};
    @(posedge clk_in);
    #1;
    {g_rd, g_wr, c_rd, c_wr} = 4'h0;
    rd = c ? c_rdata : g_rdata;
  endtask
  task automatic beat();
    int i;
    for (i = 0; i < 300; i++)
    begin
      @(negedge clk_in);
      if (src_valid === 1'b1 && src_ready === 1'b1)
        break;
    end
    b = gb;
    `CHK(i < 300, 1'b1)
  endtask
  task automatic t_regs();
    ctl(0, 0, 2'h0, 0);
    `CHK(rd[31:16], 16'h8404)
    ctl(1, 0, 2'h0, 0);
    `CHK(rd[31:16], 16'h8404)
    ctl(0, 0, 2'h1, 0);
    `CHK(rd, 32'h0000_0000)
    ctl(0, 0, 2'h3, 0);
    `CHK(rd, 32'h0000_0000)
    ctl(0, 1, 2'h1, 32'h0001_0001);
    ctl(0, 0, 2'h1, 0);
    `CHK(rd, 32'h0001_0001)
    ctl(0, 1, 2'h1, 0);
  endtask
  task automatic t_full();
    int i;
    cmd_wr(1, 0);
    ctl(0, 0, 2'h2, 0);
    `CHK(rd[15:7], 9'h000)
    repeat (16) cmd_wr(0, 32'hc000_0004);
    ctl(0, 0, 2'h2, 0);
    `CHK(rd[15:7], 9'h010)
    `CHK(rd[0], 1'b1)
    `CHK(cmd_wait, 1'b1)
    `CHK(src_valid, 1'b0)
    stall = 1;
    ctl(1, 1, 2'h1, 32'h0001_0001);
    ctl(0, 1, 2'h1, 32'h0001_0001);
    repeat (20) @(posedge clk_in);
    #1 stall = 0;
    for (i = 0; i < 60; i++)
    begin
      ctl(0, 0, 2'h2, 0);
      if (rd[15:7] === 9'h000)
        break;
    end
    `CHK(rd[15:7], 9'h000)
    repeat (30) @(posedge clk_in);
    ctl(1, 0, 2'h2, 0);
    `CHK(rd[31], 1'b0)
  endtask
  task automatic t_pattern();
    cmd_wr(0, 32'hc001_0008);
    beat();
    `CHK(b.data, 32'h0001_0203)
    `CHK(b.ch, 2'h1)
    `CHK(b.sop, 1'b1)
    beat();
    `CHK(b.data, 32'h0405_0607)
    `CHK({b.eop, b.empty}, 3'h4)
    repeat (20) @(posedge clk_in);
  endtask
  task automatic t_mask();
    cmd_wr(1, 32'h0000_00ff);
    cmd_wr(0, 32'hc002_0008);
    beat();
    `CHK(b.data, 32'hfffe_fdfc)
    repeat (40) @(posedge clk_in);
    cmd_wr(1, 0);
    ctl(1, 0, 2'h2, 0);
    `CHK(rd[31], 1'b1)
    `CHK(rd[3:0], 4'h1)
    `CHK(rd[15:8], 8'h02)
    ctl(1, 0, 2'h2, 0);
    `CHK(rd[31], 1'b0)
  endtask
  // suppressed markers and error value, then a packet left open
  task automatic t_err();
    cmd_wr(1, 32'h0003_0100);
    cmd_wr(0, 32'hc003_0006);
    beat();
    `CHK(b.sop, 1'b0)
    `CHK(b.err, 2'h1)
    beat();
    `CHK(b.data, 32'h0405_0607)
    `CHK({b.eop, b.empty}, 3'h2)
    cmd_wr(1, 0);
    cmd_wr(0, 32'h4003_0004);
    beat();
    `CHK({b.sop, b.err}, 3'h4)
    cmd_wr(0, 32'hc003_0004);
    repeat (40) @(posedge clk_in);
    ctl(1, 0, 2'h2, 0);
    `CHK(rd, 32'h8000_030a)
    ctl(1, 0, 2'h2, 0);
    `CHK(rd, 32'h8000_0304)
  endtask
  initial
  begin
    repeat (12) @(posedge clk_in);
    #1 rst_n_in = 1;
    repeat (3) @(posedge clk_in);
    t_regs();
    t_full();
    t_pattern();
    t_mask();
    t_err();
    print_verdict();
  end
endmodule
